// [verilog/fec_link_pkg.sv]
// Shared constants, field layouts and parity helpers for the 64b/66b FEC link
package fec_link_pkg;

	localparam int          BLK_W          = 64;
	localparam int          PAR_W          = 26;
	localparam int          SHS_W          = 32;
	localparam int          MB_BLOCKS      = 32;
	localparam int          IDX_W          = 5;
	localparam int          PE_W           = 4;
	localparam int          FEC_LATENCY_BLK = 58;
	localparam logic [25:0] FEC_POLY       = 26'h0220211;
	localparam logic [25:0] PAR_RESET      = 26'h0000000;
	localparam logic [1:0]  SH_ONE         = 2'h1;
	localparam logic [1:0]  SH_ZERO        = 2'h2;
	localparam int          EOEMB_BIT      = 22;
	localparam int          PAR_HI_LAST    = 21;
	localparam int          PAR3_BIT       = 23;
	localparam int          PAR_LO_BIT     = 24;
	localparam int          PILOT_LSB      = 27;
	localparam logic [4:0]  PILOT          = 5'h10;
	localparam logic [4:0]  LAST_IDX       = 5'h1f;
	localparam logic        EOEMB_E1       = 1'b1;

	// Sixty-four serial steps of the parity register, bit 0 of the block first
	function automatic logic [25:0] fec_step64(input logic [25:0] s, input logic [63:0] d);
		logic [25:0] r;
		logic        fb;
		r = s;
		for (int i = 0; i < BLK_W; i++) begin
			fb = d[i] ^ r[PAR_W-1];
			r = {r[PAR_W-2:0], 1'b0} ^ (fb ? FEC_POLY : 26'h0000000);
		end
		return r;
	endfunction

	// Place parity, end-of-extended-multiblock flag and pilot in the header stream
	function automatic logic [31:0] shs_pack(input logic [25:0] p, input logic eoemb);
		logic [31:0] s;
		s = 32'h00000000;
		for (int k = 0; k <= PAR_HI_LAST; k++) begin
			s[k] = p[PAR_W-1-k];
		end
		s[EOEMB_BIT] = eoemb;
		s[PAR3_BIT] = p[3];
		s[PAR_LO_BIT+2:PAR_LO_BIT] = {p[0], p[1], p[2]};
		s[SHS_W-1:PILOT_LSB] = PILOT;
		return s;
	endfunction

	// Recover the parity word from a received header stream
	function automatic logic [25:0] shs_parity(input logic [31:0] s);
		logic [25:0] p;
		p = 26'h0000000;
		for (int k = 0; k <= PAR_HI_LAST; k++) begin
			p[PAR_W-1-k] = s[k];
		end
		p[3] = s[PAR3_BIT];
		p[2:0] = {s[PAR_LO_BIT], s[PAR_LO_BIT+1], s[PAR_LO_BIT+2]};
		return p;
	endfunction

endpackage

// [verilog/fec_link_if.sv]
// Block-level link between the transmitting end and the receiving end
`timescale 1ns/10ps
interface fec_link_if;
	import fec_link_pkg::*;

	logic              valid;
	logic              ready;
	logic [1:0]        sync_hdr;
	logic [BLK_W-1:0]  payload;
	logic [PE_W-1:0]   serializer_preemphasis_setting;

	modport tx_end (
		output valid,
		output sync_hdr,
		output payload,
		output serializer_preemphasis_setting,
		input  ready
	);

	modport rx_end (
		input  valid,
		input  sync_hdr,
		input  payload,
		input  serializer_preemphasis_setting,
		output ready
	);

endinterface

// [verilog/fec_link_tx.sv]
// Transmitting end: two-entry buffer, FEC parity and sync header stream
`timescale 1ns/10ps
module fec_link_tx (
	input  wire logic                            ref_clk_i,
	input  wire logic                            rst_n_i,
	input  wire logic                            sysref_i,
	input  wire logic [fec_link_pkg::BLK_W-1:0]  data_i,
	input  wire logic                            valid_i,
	output logic                                 ready_o,
	input  wire logic [fec_link_pkg::PE_W-1:0]   serializer_preemphasis_setting_i,
	fec_link_if.tx_end                           link
);
	import fec_link_pkg::*;

	typedef struct packed {
		logic [1:0][BLK_W-1:0] buf_data;
		logic [1:0]            buf_vld;
		logic                  rd_ptr;
		logic                  wr_ptr;
		logic [IDX_W-1:0]      blk_idx;
		logic [PAR_W-1:0]      par;
		logic [SHS_W-1:0]      stream;
		logic [PE_W-1:0]       pe;
	} tx_state_t;

	tx_state_t st;
	tx_state_t next_st;
	logic      push;
	logic      pop;

	assign ready_o  = !st.buf_vld[st.wr_ptr];
	assign push     = valid_i && ready_o;
	assign link.valid = st.buf_vld[st.rd_ptr];
	assign pop      = link.valid && link.ready;
	assign link.payload = st.buf_data[st.rd_ptr];
	assign link.sync_hdr = st.stream[st.blk_idx] ? SH_ONE : SH_ZERO;
	assign link.serializer_preemphasis_setting = st.pe;

	always_comb begin
		next_st = st;
		next_st.pe = serializer_preemphasis_setting_i;
		if (push) begin
			next_st.buf_data[st.wr_ptr] = data_i;
			next_st.buf_vld[st.wr_ptr] = 1'b1;
			next_st.wr_ptr = !st.wr_ptr;
		end
		if (pop) begin
			next_st.buf_vld[st.rd_ptr] = 1'b0;
			next_st.rd_ptr = !st.rd_ptr;
			next_st.blk_idx = st.blk_idx + 5'h01;
			next_st.par = fec_step64(st.par, link.payload);
			if (st.blk_idx == LAST_IDX) begin
				next_st.par = PAR_RESET;
				next_st.stream = shs_pack(fec_step64(st.par, link.payload), EOEMB_E1);
			end
		end
		if (sysref_i) begin
			next_st.blk_idx = 5'h00;
			next_st.par = PAR_RESET;
			next_st.stream = shs_pack(PAR_RESET, EOEMB_E1);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.stream <= 32'h80400000;
		end else begin
			st <= next_st;
		end
	end

endmodule

// [verilog/fec_link_rx.sv]
// Receiving end: lock monitoring, syndrome check and elastic release
// Function
// - Parity covers 32 scrambled blocks, 26 bits.
// - Parity travels in the following multiblock.
// - Receiver forms syndrome; nonzero flags error.
// - First-bit error known no sooner than 58 blocks.
// - Header stream bit map for parity fields.
// - Header stream always ends with pilot 00001.
// - Pilot position confirmed over several multiblocks.
// - End-of-extended-multiblock flag on last multiblock.
// - Generator x26+x21+x17+x9+x4+1.
// - Shortened 2074/2048 code corrects nine-bit bursts; here the syndrome only flags errors, nothing is corrected.
// - Parity register cleared per multiblock, payload only.
// - Buffer at extended multiblock start after lock.
// - Release at first point after buffering began.
// - Release point set clear of arrival spread.
// - Repeated bad headers drop block lock.
// - Repeated pilot errors drop multiblock lock.
// - Repeated flag errors need SYSREF resync.
// - Pre-emphasis follows programmable setting.
// - Header 01 is one, 10 is zero.
// - One multiblock per extended multiblock.
`timescale 1ns/10ps
module fec_link_rx #(
	parameter int BLK_GOOD    = 64,
	parameter int BLK_WIN     = 64,
	parameter int BLK_ERR_MAX = 16,
	parameter int MB_CONFIRM  = 4,
	parameter int MB_WIN      = 8,
	parameter int MB_ERR_MAX  = 4,
	parameter int EMB_WIN     = 8,
	parameter int EMB_ERR_MAX = 4
) (
	input  wire logic                            ref_clk_i,
	input  wire logic                            rst_n_i,
	input  wire logic                            sysref_i,
	input  wire logic [fec_link_pkg::IDX_W-1:0]  rbd_i,
	input  wire logic                            ready_i,
	output logic [fec_link_pkg::BLK_W-1:0]       data_o,
	output logic                                 valid_o,
	output logic                                 blk_lock_o,
	output logic                                 mb_lock_o,
	output logic                                 emb_lost_o,
	output logic                                 released_o,
	output logic [fec_link_pkg::PAR_W-1:0]       syndrome_o,
	output logic                                 syndrome_valid_o,
	output logic                                 fec_error_o,
	output logic [fec_link_pkg::PE_W-1:0]        preemph_seen_o,
	fec_link_if.rx_end                           link
);
	import fec_link_pkg::*;

	if (BLK_GOOD < 1 || BLK_GOOD > 255 || BLK_WIN < 2 || BLK_WIN > 255 ||
		BLK_ERR_MAX < 2 || BLK_ERR_MAX > BLK_WIN) begin : g_chk_blk
		$error("block lock counts out of range");
	end
	if (MB_CONFIRM < 2 || MB_CONFIRM > 255 || MB_WIN < 2 || MB_WIN > 255 ||
		MB_ERR_MAX < 2 || MB_ERR_MAX > MB_WIN) begin : g_chk_mb
		$error("multiblock lock counts out of range");
	end
	if (EMB_WIN < 2 || EMB_WIN > 255 || EMB_ERR_MAX < 2 || EMB_ERR_MAX > EMB_WIN) begin : g_chk_emb
		$error("extended multiblock counts out of range");
	end

	typedef struct packed {
		logic                  blk_lock;
		logic [7:0]            good_cnt;
		logic [7:0]            blk_win;
		logic [7:0]            blk_errs;
		logic [SHS_W-1:0]      sr;
		logic [IDX_W-1:0]      pos;
		logic                  have_cand;
		logic [7:0]            hits;
		logic                  mb_lock;
		logic [7:0]            mb_win;
		logic [7:0]            mb_errs;
		logic [7:0]            emb_win;
		logic [7:0]            emb_errs;
		logic                  emb_lost;
		logic [PAR_W-1:0]      par;
		logic [PAR_W-1:0]      prev_calc;
		logic                  prev_ok;
		logic [PAR_W-1:0]      syndrome;
		logic                  syn_vld;
		logic                  buffering;
		logic                  released;
		logic [IDX_W-1:0]      lemc_cnt;
		logic [BLK_W-1:0]      data;
		logic                  dvld;
		logic [PE_W-1:0]       pe;
	} rx_state_t;

	rx_state_t st;
	rx_state_t next_st;
	logic      take;
	logic      hdr_bad;
	logic      hdr_bit;
	logic [SHS_W-1:0] sr_new;
	logic      pilot_ok;
	logic [16:0] w;

	// Windowed error count: returns {lost, window, errors}
	function automatic logic [16:0] win_step(input logic [7:0] win, input logic [7:0] errs,
		input logic err, input int win_len, input int err_max);
		logic [7:0] e;
		logic       lost;
		e = errs + {7'h00, err};
		lost = (e >= 8'(err_max));
		if (lost || win == 8'(win_len - 1)) begin
			return {lost, 8'h00, 8'h00};
		end
		return {1'b0, win + 8'h01, e};
	endfunction

	assign link.ready = ready_i;
	assign take      = link.valid && ready_i;
	assign hdr_bad   = (link.sync_hdr != SH_ONE) && (link.sync_hdr != SH_ZERO);
	assign hdr_bit   = (link.sync_hdr == SH_ONE);
	assign sr_new    = {hdr_bit, st.sr[SHS_W-1:1]};
	assign pilot_ok  = (sr_new[SHS_W-1:PILOT_LSB] == PILOT);

	assign data_o           = st.data;
	assign valid_o          = st.dvld;
	assign blk_lock_o       = st.blk_lock;
	assign mb_lock_o        = st.mb_lock;
	assign emb_lost_o       = st.emb_lost;
	assign released_o       = st.released;
	assign syndrome_o       = st.syndrome;
	assign syndrome_valid_o = st.syn_vld;
	assign fec_error_o      = st.syn_vld && (st.syndrome != PAR_RESET);
	assign preemph_seen_o   = st.pe;

	always_comb begin
		next_st = st;
		w = 17'h00000;
		next_st.syn_vld = 1'b0;
		next_st.dvld = 1'b0;
		next_st.pe = link.serializer_preemphasis_setting;
		next_st.lemc_cnt = st.lemc_cnt + 5'h01;
		if (sysref_i) begin
			next_st.lemc_cnt = 5'h00;
			next_st.emb_lost = 1'b0;
			next_st.emb_win = 8'h00;
			next_st.emb_errs = 8'h00;
		end
		if (st.buffering && !st.released && st.lemc_cnt == rbd_i) begin
			next_st.released = 1'b1;
		end
		if (take) begin
			next_st.sr = sr_new;
			next_st.pos = st.pos + 5'h01;
			if (!st.blk_lock) begin
				next_st.good_cnt = hdr_bad ? 8'h00 : st.good_cnt + 8'h01;
				if (!hdr_bad && st.good_cnt == 8'(BLK_GOOD - 1)) begin
					next_st.blk_lock = 1'b1;
					next_st.good_cnt = 8'h00;
				end
			end else begin
				w = win_step(st.blk_win, st.blk_errs, hdr_bad, BLK_WIN, BLK_ERR_MAX);
				next_st.blk_win = w[15:8];
				next_st.blk_errs = w[7:0];
				if (w[16]) begin
					next_st = '0;
					next_st.lemc_cnt = st.lemc_cnt + 5'h01;
				end
			end
			if (st.blk_lock && !w[16] && !st.mb_lock) begin
				if (!st.have_cand && pilot_ok) begin
					next_st.have_cand = 1'b1;
					next_st.hits = 8'h01;
					next_st.pos = 5'h00;
				end else if (st.have_cand && st.pos == LAST_IDX) begin
					next_st.hits = pilot_ok ? st.hits + 8'h01 : 8'h00;
					next_st.have_cand = pilot_ok;
					if (pilot_ok && st.hits == 8'(MB_CONFIRM - 1)) begin
						next_st.mb_lock = 1'b1;
						next_st.prev_ok = 1'b0;
					end
				end
			end
			if (st.mb_lock && !w[16]) begin
				next_st.par = fec_step64(st.pos == 5'h00 ? PAR_RESET : st.par, link.payload);
				if (st.pos == LAST_IDX) begin
					next_st.prev_calc = fec_step64(st.par, link.payload);
					next_st.prev_ok = 1'b1;
					next_st.syndrome = st.prev_calc ^ shs_parity(sr_new);
					next_st.syn_vld = st.prev_ok;
					w = win_step(st.mb_win, st.mb_errs, !pilot_ok, MB_WIN, MB_ERR_MAX);
					next_st.mb_win = w[15:8];
					next_st.mb_errs = w[7:0];
					if (w[16]) begin
						next_st.mb_lock = 1'b0;
						next_st.have_cand = 1'b0;
						next_st.hits = 8'h00;
						next_st.buffering = 1'b0;
						next_st.released = 1'b0;
					end
					w = win_step(st.emb_win, st.emb_errs, sr_new[EOEMB_BIT] != EOEMB_E1,
						EMB_WIN, EMB_ERR_MAX);
					next_st.emb_win = w[15:8];
					next_st.emb_errs = w[7:0];
					if (w[16]) begin
						next_st.emb_lost = 1'b1;
					end
				end
				if (st.pos == 5'h00 && !st.emb_lost) begin
					next_st.buffering = 1'b1;
				end
				if (st.released) begin
					next_st.data = link.payload;
					next_st.dvld = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule

// [tb/fec_link_checker.sv]
// Link-side assertions for the FEC sync header path
`timescale 1ns/10ps
module fec_link_checker (
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	input wire logic        valid,
	input wire logic        ready,
	input wire logic [1:0]  sync_hdr,
	input wire logic [63:0] payload
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	logic [4:0] idx;
	logic       first_mb;
	wire        hs = valid && ready;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idx <= 5'h00;
			first_mb <= 1'b1;
		end else if (hs) begin
			idx <= idx + 5'h01;
			first_mb <= first_mb && (idx != 5'h1f);
		end
	end
	property p_sh_legal; valid |-> sync_hdr == 2'h1 || sync_hdr == 2'h2; endproperty
	a_sh_legal: assert property (p_sh_legal) else $error("illegal header code");
	property p_valid_hold; valid && !ready |=> valid; endproperty
	a_valid_hold: assert property (p_valid_hold) else $error("valid dropped in stall");
	property p_data_hold; valid && !ready |=> $stable(payload) && $stable(sync_hdr); endproperty
	a_data_hold: assert property (p_data_hold) else $error("block changed in stall");
	property p_pilot_zero; hs && idx > 5'h1a && idx < 5'h1f |-> sync_hdr == 2'h2; endproperty
	a_pilot_zero: assert property (p_pilot_zero) else $error("pilot zero wrong");
	property p_pilot_one; hs && idx == 5'h1f |-> sync_hdr == 2'h1; endproperty
	a_pilot_one: assert property (p_pilot_one) else $error("pilot one wrong");
	property p_eoemb; hs && idx == 5'h16 |-> sync_hdr == 2'h1; endproperty
	a_eoemb: assert property (p_eoemb) else $error("end flag wrong");
	property p_first_zero;
		hs && first_mb && idx != 5'h16 && idx < 5'h1b |-> sync_hdr == 2'h2;
	endproperty
	a_first_zero: assert property (p_first_zero) else $error("first parity not zero");
	property p_idle_start; $rose(rst_n_i) |-> !valid; endproperty
	a_idle_start: assert property (p_idle_start) else $error("valid right after reset");
	c_mb_end: cover property (hs && idx == 5'h1f);
	c_stall: cover property (valid && !ready);
	c_first: cover property (hs && first_mb && idx == 5'h1f);
endmodule

// [tb/jesd204c_fec_sync_header_link_tb.sv]
// Testbench for the FEC sync header link, both ends
`timescale 1ns/10ps
module jesd204c_fec_sync_header_link_tb;
	import fec_link_pkg::*;
	logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, sysref = 1'b0, valid_i = 1'b0;
	logic        rdy_a = 1'b1, rdy_b = 1'b1, hold = 1'b0, b_valid = 1'b0, a_took = 1'b0;
	logic        b_had = 1'b0, b_drop = 1'b0, ready_o, blk, mbl, rel, eml, syn_v, fec_e;
	logic        blk_b, mbl_b, fec_b, v_o;
	logic [1:0]  b_hdr = 2'h2;
	logic [3:0]  pe = 4'h9, pe_seen;
	logic [4:0]  a_idx = 5'h00, rbd_a = 5'h07, rbd_b = 5'h00;
	logic [25:0] a_par = 26'h0, a_prev = 26'h0, b_prev = 26'h0, syn;
	logic [31:0] a_shs = 32'h0;
	logic [63:0] data_i = 64'h0, b_pay = 64'h0, a_last = 64'h0, d_o;
	logic [63:0] sent_q[$];
	int          failures = 0, checks = 0, cyc = 0, syn_a = 0, b_err = 0;
	fec_link_if link_a ();
	fec_link_if link_b ();
	assign link_b.valid = b_valid;
	assign link_b.sync_hdr = b_hdr;
	assign link_b.payload = b_pay;
	assign link_b.serializer_preemphasis_setting = pe;
	always #2 ref_clk_i = ~ref_clk_i;
	fec_link_tx i_fec_link_tx (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sysref_i(sysref),
		.data_i(data_i), .valid_i(valid_i), .ready_o(ready_o),
		.serializer_preemphasis_setting_i(pe), .link(link_a));
	fec_link_rx #(.BLK_GOOD(4), .MB_CONFIRM(2)) i_fec_link_rx (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.sysref_i(sysref), .rbd_i(rbd_a), .ready_i(rdy_a), .data_o(d_o), .valid_o(v_o),
		.blk_lock_o(blk), .mb_lock_o(mbl), .emb_lost_o(eml), .released_o(rel),
		.syndrome_o(syn), .syndrome_valid_o(syn_v), .fec_error_o(fec_e),
		.preemph_seen_o(pe_seen), .link(link_a));
	fec_link_rx #(.BLK_GOOD(4), .BLK_ERR_MAX(2), .MB_CONFIRM(2)) i_fec_link_rx_b (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.sysref_i(sysref), .rbd_i(rbd_b), .ready_i(rdy_b), .data_o(), .valid_o(),
		.blk_lock_o(blk_b), .mb_lock_o(mbl_b), .emb_lost_o(), .released_o(),
		.syndrome_o(), .syndrome_valid_o(), .fec_error_o(fec_b), .preemph_seen_o(),
		.link(link_b));
	fec_link_checker i_fec_link_checker (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.valid(link_a.valid), .ready(link_a.ready), .sync_hdr(link_a.sync_hdr),
		.payload(link_a.payload));
	function automatic logic [25:0] fec_serial(input logic [25:0] s, input logic [63:0] d);
		for (int i = 0; i < 64; i++) begin
			s = {s[24:0], 1'b0} ^ ((d[i] ^ s[25]) ? 26'h0220211 : 26'h0);
		end
		return s;
	endfunction
	function automatic logic [31:0] shs_expect(input logic [25:0] p);
		shs_expect = {5'h10, p[0], p[1], p[2], p[3], 1'b1, 22'h0};
		for (int k = 0; k < 22; k++) begin
			shs_expect[k] = p[25-k];
		end
	endfunction
	task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic send_a(input int n);
		logic hs;
		for (int i = 0; i < n; i++) begin
			data_i <= {32'h5a5a0f0f ^ 32'(i), 32'h9e3779b1 * 32'(i)};
			valid_i <= 1'b1;
			do begin
				@(negedge ref_clk_i);
				hs = ready_o;
				@(posedge ref_clk_i);
			end while (!hs);
		end
		valid_i <= 1'b0;
	endtask
	task automatic send_b(input int nmb, input int bad, input logic hdr_bad);
		logic [31:0] s;
		logic [25:0] p;
		logic [63:0] w;
		for (int m = 0; m < nmb; m++) begin
			s = shs_expect(b_prev);
			p = 26'h0;
			for (int i = 0; i < 32; i++) begin
				w = {32'h3c3c7e01 ^ 32'(m), 32'h9e3779b1 * 32'(i + 7)};
				p = fec_serial(p, w);
				b_valid <= 1'b1;
				b_pay <= (m == bad && i == 5 && !hdr_bad) ? w ^ 64'h10 : w;
				b_hdr <= (m == bad && hdr_bad && i > 2 && i < 6) ? 2'h0 : (s[i] ? 2'h1 : 2'h2);
				do begin
					@(posedge ref_clk_i);
				end while (!rdy_b);
			end
			b_prev = p;
		end
		b_valid <= 1'b0;
	endtask
	always @(posedge ref_clk_i) begin
		cyc++;
		rdy_a <= hold ? 1'b0 : (cyc % 5 != 2);
		rdy_b <= (cyc % 7 != 3);
		if (cyc == 5000) begin
			failures++;
			tally_and_finish();
		end
		if (valid_i && ready_o)
			sent_q.push_back(data_i);
		if (v_o === 1'b1)
			check("rx_data", a_took ? a_last : ~a_last, d_o);
		a_took = 1'b0;
		if (link_a.valid && link_a.ready) begin
			a_took = 1'b1;
			a_last = link_a.payload;
			check("tx_order", sent_q.pop_front(), link_a.payload);
			a_shs[a_idx] = (link_a.sync_hdr === 2'h1);
			a_par = fec_serial(a_par, link_a.payload);
			if (a_idx == 5'h1f) begin
				check("shs", 64'(shs_expect(a_prev)), 64'(a_shs));
				a_prev = a_par;
				a_par = 26'h0;
			end
			a_idx++;
		end
		if (syn_v === 1'b1) begin
			syn_a++;
			check("syndrome", 64'h0, 64'({syn, fec_e}));
		end
		if (fec_b === 1'b1)
			b_err++;
		if (blk_b === 1'b1)
			b_had = 1'b1;
		else if (b_had)
			b_drop = 1'b1;
	end
	initial begin
		repeat (6) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		sysref <= 1'b1;
		@(posedge ref_clk_i);
		sysref <= 1'b0;
		hold <= 1'b1;
		send_a(2);
		@(negedge ref_clk_i);
		check("tx_full", 64'h0, 64'(ready_o));
		check("pe_seen", 64'h9, 64'(pe_seen));
		@(posedge ref_clk_i);
		hold <= 1'b0;
		pe <= 4'h3;
		send_a(300);
		repeat (8) @(posedge ref_clk_i);
		check("rx_state", 64'he, 64'({blk, mbl, rel, eml}));
		check("syn_seen", 64'h1, 64'(syn_a > 2));
		check("pe_seen", 64'h3, 64'(pe_seen));
		send_b(12, 9, 1'b0);
		repeat (4) @(posedge ref_clk_i);
		check("fec_err_b", 64'h1, 64'(b_err));
		check("mb_lock_b", 64'h1, 64'(mbl_b));
		send_b(2, 0, 1'b1);
		repeat (4) @(posedge ref_clk_i);
		check("blk_drop_b", 64'h1, 64'(b_drop));
		tally_and_finish();
	end
endmodule
